// [src/eepc_pkg.sv]
// Package for the nonvolatile program/erase control block.
// Assumes a byte-wide register port and a 4 Kbyte array behind it.
package eepc_pkg;
   // Register indices on the plain register port
   localparam logic [1:0] EEPC_OFS_CONFIG = 2'h0;
   localparam logic [1:0] EEPC_OFS_PROTECT = 2'h1;
   localparam logic [1:0] EEPC_OFS_TEST = 2'h2;
   localparam logic [1:0] EEPC_OFS_PROG = 2'h3;
   // Module configuration fields
   localparam int EEPC_CFG_WAIT_STOP = 2;
   localparam int EEPC_CFG_LOCK = 1;
   localparam int EEPC_CFG_PUMP_RC = 0;
   // Test register fields
   localparam int EEPC_TST_ODD = 7;
   localparam int EEPC_TST_EVEN = 6;
   localparam int EEPC_TST_MARGIN = 5;
   localparam int EEPC_TST_PUMP_OFF = 4;
   localparam int EEPC_TST_RAMP_OFF = 3;
   localparam int EEPC_TST_MONITOR = 1;
   localparam logic [7:0] EEPC_TST_MASK = 8'hfa;
   // Program control fields
   localparam int EEPC_PRG_BULK_GUARD = 6;
   localparam int EEPC_PRG_SIZE = 4;
   localparam int EEPC_PRG_ROW = 3;
   localparam int EEPC_PRG_ERASE = 2;
   localparam int EEPC_PRG_LATCH = 1;
   localparam int EEPC_PRG_HV = 0;
   localparam logic [7:0] EEPC_PRG_MASK = 8'h5f;
   localparam logic [7:0] EEPC_RESET_ZERO = 8'h00;
   // Array geometry and protect ranges, offsets within the array
   localparam int EEPC_ADDR_W = 12;
   localparam int EEPC_ROW_LSB = 5;
   localparam logic [11:0] EEPC_RANGE_START [7] =
      '{12'hfc0, 12'hf80, 12'hf00, 12'he00, 12'hc00, 12'h800, 12'h000};
   localparam logic [11:0] EEPC_RANGE_END [7] =
      '{12'hfff, 12'hfbf, 12'hf7f, 12'heff, 12'hdff, 12'hbff, 12'h7ff};
   // Pump ramp steps
   localparam int EEPC_RAMP_W = 4;
   localparam logic [3:0] EEPC_RAMP_FULL = 4'hf;

   typedef enum logic [3:0] {
      EEPC_OP_NONE = 4'b0001,
      EEPC_OP_WORD = 4'b0010,
      EEPC_OP_ROW = 4'b0100,
      EEPC_OP_BULK = 4'b1000
   } eepc_op_t;
endpackage

// [src/eepc_array_if.sv]
// Carries latched operation requests from the control core to the protect check.
// Assumes both ends share clk.
`timescale 1ns/1ns
interface eepc_array_if;
   logic [11:0] addr;
   logic [6:0] protect;
   logic erase;
   logic [3:0] op;
   logic allowed;
   modport ctrl (output addr, output protect, output erase, output op, input allowed);
   modport check (input addr, input protect, input erase, input op, output allowed);
endinterface

// [src/eepc_protect_check.sv]
// Decides whether a latched operation may touch the array.
// Assumes the control core drives stable latched values.
`timescale 1ns/1ns
module eepc_protect_check
   import eepc_pkg::*;
(
   eepc_array_if.check chk,
   input wire logic bulk_guard
);
   function automatic logic hit(input logic [11:0] a, input int i);
      hit = (a >= EEPC_RANGE_START[i]) && (a <= EEPC_RANGE_END[i]);
   endfunction

   logic [6:0] blocked;
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_rng
         // Whole-array ops collide with any set protect bit
         assign blocked[g] = chk.protect[g] &&
            (hit(chk.addr, g) || chk.op == EEPC_OP_BULK);
      end
   endgenerate

   // Guard blocks row and bulk erase only
   assign chk.allowed = (blocked == 7'h00) &&
      !(chk.erase && bulk_guard &&
        (chk.op == EEPC_OP_ROW || chk.op == EEPC_OP_BULK));
endmodule

// [src/eepc_control.sv]
// Program/erase control for the on-chip nonvolatile array.
// Assumes a synchronous CPU register port and array write port on clk.
// How it works
// - Wait-stop bit gates module clock in wait
// - Lock freezes protect and guard; once normally
// - Pump clock select picks RC or system
// - Protect writes need apply and lock clear
// - Seven protect bits block their ranges
// - Test register writable only in special modes
// - Odd/even bulk bits target row parity
// - Margin bit selects margin test condition
// - Pump runs unless disabled; ramps unless disabled
// - Guard refuses bulk and row erase
// - Size and row bits select erase size
// - Size and row ignored when programming
// - Single erase uses latched address and width
// - Erase select writable only without apply
// - Latch bit captures writes, blocks reads
// - Option bits accepted together or separately
// - Apply sets only after latch already set
// - Apply freezes guard, size, row, erase, latch
// - Apply freezes latches and ignores writes
// - Misaligned word latches lower byte only
// - Stop removes voltage, keeps apply bit
`timescale 1ns/1ns
module eepc_control
   import eepc_pkg::*;
#(
   parameter int ADDR_W = EEPC_ADDR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic special_mode_n,
   input wire logic wait_mode,
   input wire logic stop_mode,
   input wire logic arr_wr,
   input wire logic arr_word,
   input wire logic [ADDR_W-1:0] arr_addr,
   input wire logic [15:0] arr_wdata,
   output logic arr_read_block,
   output logic module_clk_en,
   output logic rc_osc_en,
   output logic pump_clk_rc,
   output logic hv_on,
   output logic [EEPC_RAMP_W-1:0] pump_level,
   output logic pump_monitor,
   output logic margin_test,
   output logic [1:0] row_parity_sel,
   output logic [3:0] op_size,
   output logic op_erase,
   output logic op_word,
   output logic [ADDR_W-1:0] op_addr,
   output logic [15:0] op_data
);
   logic [2:0] config_reg;
   logic lock_written_reg;
   logic [6:0] protect_reg;
   logic [7:0] test_reg;
   logic [7:0] prog_reg;
   logic [ADDR_W-1:0] lat_addr_reg;
   logic [15:0] lat_data_reg;
   logic lat_word_reg;
   logic [EEPC_RAMP_W-1:0] ramp_reg;
   logic [7:0] rdata_next;
   logic hv_bit;
   logic latch_bit;
   logic wr_cfg, wr_prot, wr_test, wr_prog;
   logic op_allowed;
   eepc_op_t op_kind;
   eepc_array_if aif ();

   function automatic logic is_wr(input logic [1:0] a, input logic [1:0] ofs,
                                  input logic we);
      is_wr = we && (a == ofs);
   endfunction

   assign wr_cfg = is_wr(reg_addr, EEPC_OFS_CONFIG, reg_wr);
   assign wr_prot = is_wr(reg_addr, EEPC_OFS_PROTECT, reg_wr);
   assign wr_test = is_wr(reg_addr, EEPC_OFS_TEST, reg_wr);
   assign wr_prog = is_wr(reg_addr, EEPC_OFS_PROG, reg_wr);
   assign hv_bit = prog_reg[EEPC_PRG_HV];
   assign latch_bit = prog_reg[EEPC_PRG_LATCH];

   // Module configuration: wait-stop and pump clock anytime; lock per mode
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         config_reg <= 3'h0;
         lock_written_reg <= 1'b0;
      end
      else if (wr_cfg)
      begin
         config_reg[EEPC_CFG_WAIT_STOP] <= reg_wdata[EEPC_CFG_WAIT_STOP];
         config_reg[EEPC_CFG_PUMP_RC] <= reg_wdata[EEPC_CFG_PUMP_RC];
         // Normal mode: first write counts, later ones cannot change it
         if (!special_mode_n || !lock_written_reg)
            config_reg[EEPC_CFG_LOCK] <= reg_wdata[EEPC_CFG_LOCK];
         lock_written_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         protect_reg <= 7'h00;
      else if (wr_prot && !hv_bit && !config_reg[EEPC_CFG_LOCK])
         protect_reg <= reg_wdata[6:0];
   end

   // Normal modes force test bits low
   always_ff @(posedge clk)
   begin
      if (!rst_n || special_mode_n)
         test_reg <= EEPC_RESET_ZERO;
      else if (wr_test)
         test_reg <= reg_wdata & EEPC_TST_MASK;
   end

   // Program register; option fields taken from one write, apply only once latch is already set
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         prog_reg <= EEPC_RESET_ZERO;
      else if (wr_prog)
      begin
         if (!hv_bit)
         begin
            if (!config_reg[EEPC_CFG_LOCK])
               prog_reg[EEPC_PRG_BULK_GUARD] <= reg_wdata[EEPC_PRG_BULK_GUARD];
            prog_reg[EEPC_PRG_SIZE] <= reg_wdata[EEPC_PRG_SIZE];
            prog_reg[EEPC_PRG_ROW] <= reg_wdata[EEPC_PRG_ROW];
            prog_reg[EEPC_PRG_ERASE] <= reg_wdata[EEPC_PRG_ERASE];
            prog_reg[EEPC_PRG_LATCH] <= reg_wdata[EEPC_PRG_LATCH];
         end
         // Apply needs the latch bit already set before this write
         prog_reg[EEPC_PRG_HV] <= reg_wdata[EEPC_PRG_HV] && latch_bit;
      end
   end

   // Address and data latches
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         lat_addr_reg <= '0;
         lat_data_reg <= 16'h0000;
         lat_word_reg <= 1'b0;
      end
      else if (arr_wr && latch_bit && !hv_bit)
      begin
         lat_addr_reg <= arr_addr;
         // Misaligned word degrades to its lower byte
         lat_word_reg <= arr_word && !arr_addr[0];
         // Byte ops keep only the low byte, so the data output is a flop
         if (arr_word && !arr_addr[0])
            lat_data_reg <= arr_wdata;
         else
            lat_data_reg <= {8'h00, arr_wdata[7:0]};
      end
   end

   // Progressive pump ramp while voltage is on
   always_ff @(posedge clk)
   begin
      if (!rst_n || !hv_on)
         ramp_reg <= '0;
      else if (ramp_reg != EEPC_RAMP_FULL)
         ramp_reg <= ramp_reg + 1'b1;
   end

   always_comb
   begin
      if (!prog_reg[EEPC_PRG_ERASE])
         op_kind = EEPC_OP_NONE;
      else if (prog_reg[EEPC_PRG_SIZE])
         op_kind = EEPC_OP_WORD;
      else if (prog_reg[EEPC_PRG_ROW])
         op_kind = EEPC_OP_ROW;
      else
         op_kind = EEPC_OP_BULK;
   end

   assign aif.addr = lat_addr_reg[EEPC_ADDR_W-1:0];
   assign aif.protect = protect_reg;
   assign aif.erase = prog_reg[EEPC_PRG_ERASE];
   assign aif.op = op_kind;
   assign op_allowed = aif.allowed;

   eepc_protect_check u_check (
      .chk (aif.check),
      .bulk_guard (prog_reg[EEPC_PRG_BULK_GUARD])
   );

   // Stop mode drops voltage but the apply bit stays set
   assign hv_on = hv_bit && !stop_mode && op_allowed &&
      !test_reg[EEPC_TST_PUMP_OFF];
   assign pump_level = test_reg[EEPC_TST_RAMP_OFF] ? EEPC_RAMP_FULL : ramp_reg;
   assign module_clk_en = !(wait_mode && config_reg[EEPC_CFG_WAIT_STOP]);
   assign pump_clk_rc = config_reg[EEPC_CFG_PUMP_RC];
   assign rc_osc_en = config_reg[EEPC_CFG_PUMP_RC] && !stop_mode;
   assign arr_read_block = latch_bit;
   assign margin_test = test_reg[EEPC_TST_MARGIN];
   assign pump_monitor = test_reg[EEPC_TST_MONITOR];
   assign row_parity_sel = {test_reg[EEPC_TST_ODD], test_reg[EEPC_TST_EVEN]};
   assign op_size = op_kind;
   assign op_erase = prog_reg[EEPC_PRG_ERASE];
   assign op_word = lat_word_reg;
   assign op_addr = lat_addr_reg;
   assign op_data = lat_data_reg;

   always_comb
   begin
      case (reg_addr)
         EEPC_OFS_CONFIG: rdata_next = {5'h00, config_reg};
         EEPC_OFS_PROTECT: rdata_next = {1'b0, protect_reg};
         EEPC_OFS_TEST: rdata_next = test_reg;
         EEPC_OFS_PROG: rdata_next = prog_reg & EEPC_PRG_MASK;
         default: rdata_next = EEPC_RESET_ZERO;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reg_rdata <= EEPC_RESET_ZERO;
      else if (reg_rd)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= EEPC_RESET_ZERO;
   end

   sequence s_latch_set;
      wr_prog && !hv_bit && reg_wdata[EEPC_PRG_LATCH] && !latch_bit;
   endsequence

   sequence s_locked_normal;
      special_mode_n && lock_written_reg;
   endsequence

   sequence s_array_take;
      arr_wr && latch_bit && !hv_bit;
   endsequence

   a_hv_needs_latch: assert property (@(posedge clk) disable iff (!rst_n)
      s_latch_set ##1 1'b1 |-> !hv_bit)
      else $error("apply set together with latch");
   a_prot_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      (hv_bit || config_reg[EEPC_CFG_LOCK]) |=> $stable(protect_reg))
      else $error("protect changed while frozen");
   a_test_zero: assert property (@(posedge clk) disable iff (!rst_n)
      special_mode_n |=> test_reg == EEPC_RESET_ZERO)
      else $error("test bits set in normal mode");
   a_opts_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      hv_bit |=> $stable(prog_reg[6:1]))
      else $error("options changed under apply");
   a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
      hv_bit |=> $stable(lat_addr_reg) && $stable(lat_data_reg))
      else $error("latches changed under apply");
   a_stop_hv: assert property (@(posedge clk) disable iff (!rst_n)
      stop_mode |-> !hv_on && !rc_osc_en)
      else $error("voltage on during stop");
   a_wait_clk: assert property (@(posedge clk) disable iff (!rst_n)
      wait_mode && config_reg[EEPC_CFG_WAIT_STOP] |-> !module_clk_en)
      else $error("clock running in wait");
   a_read_block: assert property (@(posedge clk) disable iff (!rst_n)
      wr_prog && !hv_bit |=> arr_read_block == $past(reg_wdata[EEPC_PRG_LATCH]))
      else $error("array readable while latched");
   a_ramp_grow: assert property (@(posedge clk) disable iff (!rst_n)
      hv_on && !test_reg[EEPC_TST_RAMP_OFF] && ramp_reg == '0 |=> hv_on[*1] ##0 ramp_reg == 4'h1
      or !hv_on)
      else $error("pump did not ramp");
   a_lock_once: assert property (@(posedge clk) disable iff (!rst_n)
      s_locked_normal |=> $stable(config_reg[EEPC_CFG_LOCK]))
      else $error("lock rewritten in normal mode");
   a_guard_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      hv_bit || config_reg[EEPC_CFG_LOCK] |=> $stable(prog_reg[EEPC_PRG_BULK_GUARD]))
      else $error("guard changed while frozen");
   a_guard_blocks: assert property (@(posedge clk) disable iff (!rst_n)
      prog_reg[EEPC_PRG_BULK_GUARD] && (op_kind == EEPC_OP_ROW || op_kind == EEPC_OP_BULK)
      |-> !hv_on)
      else $error("guarded erase got voltage");
   a_bulk_protect: assert property (@(posedge clk) disable iff (!rst_n)
      op_kind == EEPC_OP_BULK && protect_reg != 7'h00 |-> !hv_on)
      else $error("bulk erase over protected block");
   // One check per protect range
   for (genvar r = 0; r < 7; r++)
   begin : g_range_chk
      a_range_protect: assert property (@(posedge clk) disable iff (!rst_n)
         protect_reg[r] && lat_addr_reg >= EEPC_RANGE_START[r] &&
         lat_addr_reg <= EEPC_RANGE_END[r] |-> !hv_on)
         else $error("protected range got voltage");
   end
   a_latch_take: assert property (@(posedge clk) disable iff (!rst_n)
      s_array_take |=> op_addr == $past(arr_addr))
      else $error("array write not latched");
   a_odd_byte: assert property (@(posedge clk) disable iff (!rst_n)
      s_array_take ##0 arr_addr[0] |=> !op_word && op_data[15:8] == 8'h00)
      else $error("misaligned word kept its upper byte");
   a_rc_select: assert property (@(posedge clk) disable iff (!rst_n)
      wr_cfg |=> pump_clk_rc == $past(reg_wdata[EEPC_CFG_PUMP_RC]))
      else $error("pump clock select not written");
   a_test_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_test && !special_mode_n |=> test_reg == ($past(reg_wdata) & EEPC_TST_MASK))
      else $error("test write lost in special mode");
   a_apply_sets: assert property (@(posedge clk) disable iff (!rst_n)
      wr_prog && reg_wdata[EEPC_PRG_HV] && latch_bit |=> hv_bit)
      else $error("apply refused with latch set");
endmodule

// [verification/eepc_array_model.sv]
// Behavioural cell array behind the control block.
// Assumes latched operation outputs stay steady while voltage is on.
`timescale 1ns/1ns
module eepc_array_model
   import eepc_pkg::*;
(
   input wire logic clk,
   input wire logic hv_on,
   input wire logic op_erase,
   input wire logic [11:0] op_addr,
   input wire logic [15:0] op_data,
   input wire logic [11:0] probe_addr,
   output logic [7:0] probe_data
);
   logic [7:0] mem_reg [4096];
   // Cells change only under voltage, so stray writes cannot corrupt them
   always_ff @(posedge clk)
   begin
      if (hv_on)
      begin
         mem_reg[op_addr] <= op_erase ? 8'hff : op_data[7:0];
      end
   end
   assign probe_data = mem_reg[probe_addr];
endmodule

// [verification/tb.sv]
// Self-checking bench for the program/erase control block.
// Assumes the array model stands behind the latched operation outputs.
`timescale 1ns/1ns
module tb;
   import eepc_pkg::*;
   logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
   logic special_mode_n = 1, wait_mode = 0, stop_mode = 0, arr_wr = 0, arr_word = 0;
   logic [1:0] reg_addr = 2'h0, row_parity_sel;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, probe_data;
   logic [11:0] arr_addr = 12'h000, op_addr, adr;
   logic [15:0] arr_wdata = 16'h0000, op_data, dat;
   logic arr_read_block, module_clk_en, rc_osc_en, pump_clk_rc, hv_on;
   logic pump_monitor, margin_test, op_erase, op_word;
   logic [3:0] pump_level, op_size;
   logic [7:0] exp_q [$];
   logic [7:0] t_val [5] = '{8'h08, 8'h10, 8'h00, 8'h00, 8'h00};
   logic [7:0] p_val [5] = '{8'h02, 8'h02, 8'h02, 8'h4e, 8'h0e};
   logic e_hv [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [7:0] s_prg [3] = '{8'h16, 8'h0e, 8'h06};
   logic [3:0] s_exp [3] = '{4'h2, 4'h4, 4'h8};
   int bad_count = 0, total_checks = 0;
   always #50 clk = ~clk;
   eepc_control eepc_control_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .special_mode_n, .wait_mode, .stop_mode, .arr_wr, .arr_word, .arr_addr,
      .arr_wdata, .arr_read_block, .module_clk_en, .rc_osc_en, .pump_clk_rc, .hv_on,
      .pump_level, .pump_monitor, .margin_test, .row_parity_sel, .op_size, .op_erase,
      .op_word, .op_addr, .op_data);
   eepc_array_model eepc_array_model_i (.clk, .hv_on, .op_erase, .op_addr, .op_data,
      .probe_addr(adr), .probe_data);
   task automatic tally_and_finish();
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic fail(input string m);
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
         fail($sformatf("got %h want %h", got, exp));
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 0;
      #1;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 0;
      #1;
   endtask
   task automatic aw(input logic [11:0] a, input logic [15:0] d, input logic w);
      @(posedge clk);
      arr_wr <= 1;
      arr_addr <= a;
      arr_wdata <= d;
      arr_word <= w;
      @(posedge clk);
      arr_wr <= 0;
      #1;
   endtask
   task automatic pins(input logic s, input logic w, input logic m);
      @(posedge clk);
      stop_mode <= s;
      wait_mode <= w;
      special_mode_n <= m;
      @(posedge clk);
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_d)
      begin
         total_checks++;
         if (reg_rdata !== exp_q[0])
            fail($sformatf("read %h want %h", reg_rdata, exp_q[0]));
         exp_q.delete(0);
      end
      rd_d <= reg_rd;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      void'($urandom(32'h3bf27aad));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 4; i++)
         rd(i[1:0], 8'h00);
      wr(EEPC_OFS_TEST, 8'hff);
      rd(EEPC_OFS_TEST, 8'h00);
      wr(EEPC_OFS_CONFIG, 8'h07);
      chk({pump_clk_rc, rc_osc_en}, 32'h3);
      pins(1, 1, 1);
      chk({pump_clk_rc, rc_osc_en, module_clk_en}, 32'h4);
      pins(0, 0, 1);
      chk(module_clk_en, 32'h1);
      wr(EEPC_OFS_PROTECT, 8'h7f);
      rd(EEPC_OFS_PROTECT, 8'h00);
      wr(EEPC_OFS_CONFIG, 8'h00);
      rd(EEPC_OFS_CONFIG, 8'h02);
      pins(0, 0, 0);
      wr(EEPC_OFS_CONFIG, 8'h00);
      rd(EEPC_OFS_CONFIG, 8'h00);
      wr(EEPC_OFS_PROTECT, 8'h40);
      rd(EEPC_OFS_PROTECT, 8'h40);
      wr(EEPC_OFS_TEST, 8'hff);
      rd(EEPC_OFS_TEST, 8'hfa);
      chk({row_parity_sel, margin_test, pump_monitor}, 32'hf);
      wr(EEPC_OFS_TEST, 8'h00);
      dat = 16'($urandom);
      adr = {1'b1, 11'($urandom)};
      // Size and row set while programming must not matter
      wr(EEPC_OFS_PROG, 8'h1b);
      rd(EEPC_OFS_PROG, 8'h1a);
      chk({arr_read_block, op_size}, 32'h11);
      aw(adr, dat, 0);
      wr(EEPC_OFS_PROG, 8'h1b);
      chk({hv_on, op_size}, 32'h11);
      aw(adr ^ 12'h004, ~dat, 0);
      wr(EEPC_OFS_PROG, 8'h05);
      rd(EEPC_OFS_PROG, 8'h1b);
      chk({op_addr, op_data[7:0]}, {adr, dat[7:0]});
      pins(1, 0, 0);
      chk(hv_on, 32'h0);
      rd(EEPC_OFS_PROG, 8'h1b);
      pins(0, 0, 0);
      chk({hv_on, pump_level}, 32'h11);
      wr(EEPC_OFS_PROG, 8'h1a);
      chk(hv_on, 32'h0);
      wr(EEPC_OFS_PROG, 8'h00);
      chk({arr_read_block, probe_data}, {1'b0, dat[7:0]});
      // Ramp off, pump off, protected range, guard, plain row erase
      for (int i = 0; i < 5; i++)
      begin
         wr(EEPC_OFS_TEST, t_val[i]);
         wr(EEPC_OFS_PROG, p_val[i]);
         aw((i == 2) ? 12'h100 : adr, dat, 0);
         wr(EEPC_OFS_PROG, p_val[i] | 8'h01);
         chk({hv_on, (i == 0) ? pump_level : 4'hf}, {e_hv[i], 4'hf});
         wr(EEPC_OFS_PROG, p_val[i]);
         wr(EEPC_OFS_PROG, 8'h00);
      end
      wr(EEPC_OFS_PROG, 8'h04);
      wr(EEPC_OFS_PROG, 8'h06);
      rd(EEPC_OFS_PROG, 8'h06);
      for (int i = 0; i < 3; i++)
      begin
         wr(EEPC_OFS_PROG, s_prg[i]);
         chk({op_erase, op_size}, {1'b1, s_exp[i]});
      end
      wr(EEPC_OFS_PROG, 8'h02);
      aw(12'h803, dat, 1);
      chk({op_word, op_data}, {9'h000, dat[7:0]});
      aw(12'h804, ~dat, 1);
      chk({op_word, op_addr, op_data}, {1'b1, 12'h804, ~dat});
      wr(EEPC_OFS_PROG, 8'h00);
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule
